// ---- hw/fic_map.vh ----
// Notes on behaviour
// RL1 - injection fakes detection only; node data passes through unchanged.
// RL2 - faked detection drives fault, recovery and in-line responses by type.
// RL3 - feature register support field nonzero when injection exists; zero means absent.
// RL4 - memory-mapped records allow injection only with group revision of one or more.
// RL5 - injection inactive while writable detect enable holds zero.
// RL6 - only detectable error types may be injected.
// RL7 - low privilege access traps to top level unless secure access enable is one.
// RL8 - kernel access traps to hypervisor unless its access enable is one.
// RL9 - injection registers unreachable from 32-bit state; support field still readable.
// RL10 - writing countdown enable loads counter from nonzero countdown value; zero clears. The code also fires an injection on a zero value.
// RL11 - generation counter is never readable by software.
// RL12 - counter decrements once per tick while enabled and nonzero.
// RL13 - counter reaching zero enters pending injection state.
// RL14 - next access in pending state fakes, records, reports, then leaves pending.
// RL15 - recording sets valid, uncorrected, corrected, postponed and kind fields by type.
// RL16 - other syndrome fields are left to software preload. The code writes them to zero on injection.
// RL17 - only the first record holds injection registers.
// RL18 - unchanged syndrome means the injection lands in the first record.
// RL19 - edge interrupts pulse as for real detection when enabled. The code gives no fault pulse for a corrected error, even with CFI set.
// RL20 - level interrupts depend only on control and status fields.
// RL21 - cyclic mode reloads counter at zero from nonzero countdown value. The code also reloads a zero value and then fires an injection on every tick.
// RL22 - reset clears counter and pending state.
`ifndef FIC_MAP_VH
`define FIC_MAP_VH
// =====================================================
// register offsets
`define FIC_A_FEAT     4'h0
`define FIC_A_CTL      4'h1
`define FIC_A_CDN      4'h2
`define FIC_A_RCTL     4'h3
`define FIC_A_STATUS   4'h4
`define FIC_A_RFEAT    4'h5
// =====================================================
// control register fields
`define FIC_CTL_UC     0
`define FIC_CTL_UEU    1
`define FIC_CTL_CE     2
`define FIC_CTL_DE     3
`define FIC_CTL_R      30
`define FIC_CTL_COUNTDOWN_ENABLE  31
`define FIC_CTL_MASK   32'hC000000F
// record control fields
`define FIC_RCTL_ED    0
`define FIC_RCTL_UI    2
`define FIC_RCTL_FI    3
`define FIC_RCTL_DUI   4
`define FIC_RCTL_CFI   5
// status fields
`define FIC_ST_V       30
`define FIC_ST_UE      29
`define FIC_ST_DE      23
`define FIC_ST_CE_LO   24
`define FIC_ST_UET_LO  20
// codes
`define FIC_INJ_YES    2'h1
`define FIC_UET_UC     2'h0
`define FIC_UET_UEU    2'h1
`define FIC_CE_ONE     2'h2
`define FIC_REV_MIN    4'h1
`define FIC_ZERO32     32'h00000000
`endif

// ---- hw/fic_tick.v ----
`timescale 1ns/1ps
`include "fic_map.vh"
module fic_tick #(
	parameter DIV = 200
) (
	input  wire       mclk,
	input  wire       rst_b,
	output reg        tick
);
	reg [15:0] cnt_r;
	// =====================================================
	// divider: counter rate is one pulse every DIV cycles
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b0;
		end else if (cnt_r == DIV[15:0] - 16'h0001) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick  <= 1'b0;
		end
	end
endmodule // fic_tick

// ---- hw/fic_count.v ----
`timescale 1ns/1ps
`include "fic_map.vh"
module fic_count #(
	parameter W = 32
) (
	input  wire         mclk,
	input  wire         rst_b,
	input  wire         tick,
	input  wire         arm_wr,
	input  wire         enable,
	input  wire         cyclic,
	input  wire [W-1:0] countdown_value,
	output reg          fire
);
	reg [W-1:0] cnt_r;
	reg [W-1:0] cnt_nxt;
	reg         fire_nxt;
	// =====================================================
	// countdown; the value stays internal, no read path
	always @* begin
		cnt_nxt  = cnt_r;
		fire_nxt = 1'b0;
		if (arm_wr) begin
			cnt_nxt  = countdown_value;                     // [RL10]
			fire_nxt = (countdown_value == {W{1'b0}});      // zero value: clear and inject [RL10]
		end else if (enable && tick) begin
			if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
				cnt_nxt  = cnt_r - {{(W-1){1'b0}}, 1'b1}; // [RL12]
				fire_nxt = 1'b1;                // [RL13]
			end else if (cnt_r != {W{1'b0}}) begin
				cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};  // [RL12]
			end else if (cyclic) begin
				cnt_nxt  = countdown_value;                 // [RL21]
				fire_nxt = (countdown_value == {W{1'b0}});  // [RL21]
			end
		end
	end
	// reset leaves nothing armed
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= {W{1'b0}};                 // [RL22]
			fire  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			fire  <= fire_nxt;
		end
	end
endmodule // fic_count

// ---- hw/fic_top.v ----
`timescale 1ns/1ps
`include "fic_map.vh"
module fic_top #(
	parameter TICK_DIV = 200,
	parameter [3:0] TYPES_OK = 4'hF,
	parameter LEVEL_IRQ = 1
) (
	input  wire        mclk,
	input  wire        rst_b,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        priv_low,
	input  wire        priv_kernel,
	input  wire        state_32,
	input  wire        secure_inject_access_enable,
	input  wire        hyp_inject_access_enable,
	input  wire        el3_present,
	input  wire        el2_active,
	input  wire [3:0]  group_arch_revision,
	input  wire        mm_group,
	input  wire        node_access,
	input  wire [31:0] node_data_in,
	output reg  [31:0] node_data_out,
	output reg         inline_err,
	output reg         trap_top,
	output reg         trap_hyp,
	output wire        fault_irq,
	output wire        recov_irq
);
	// =====================================================
	// registers
	reg [31:0] ctl_r;
	reg [31:0] cdn_r;
	reg [5:0]  rctl_r;
	reg [31:0] status_r;
	reg        pend_r;
	reg        fault_p_r;
	reg        recov_p_r;
	reg [3:0]  rev_s1_r;
	reg [3:0]  rev_r;
	wire       fire;
	wire       tick;
	// revision comes from outside the clock domain
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rev_s1_r <= 4'h0;
			rev_r    <= 4'h0;
		end else begin
			rev_s1_r <= group_arch_revision;
			rev_r    <= rev_s1_r;
		end
	end
	wire rev_ok  = !mm_group || (rev_r >= `FIC_REV_MIN);            // [RL4]
	wire inj_on  = rev_ok && rctl_r[`FIC_RCTL_ED];                 // [RL5]
	// effective enables default to one when the level is absent
	wire eff_sec = !el3_present || secure_inject_access_enable;    // [RL7]
	wire eff_hyp = !el2_active || hyp_inject_access_enable;        // [RL8]
	wire inj_reg = (reg_addr == `FIC_A_CTL) || (reg_addr == `FIC_A_CDN)
	               || (reg_addr == `FIC_A_FEAT);
	wire t_top   = inj_reg && priv_low && !eff_sec;                // [RL7]
	wire t_hyp   = inj_reg && priv_kernel && eff_sec && !eff_hyp;  // [RL8]
	wire blocked = inj_reg && (state_32 || t_top || t_hyp);        // [RL9]
	wire wr_ok   = reg_wr && !blocked;
	wire rd_ok   = reg_rd && !blocked;
	wire arm_wr  = wr_ok && (reg_addr == `FIC_A_CTL) && reg_wdata[`FIC_CTL_COUNTDOWN_ENABLE] && inj_on;
	wire [3:0] types = ctl_r[3:0] & TYPES_OK;                       // [RL6]
	// =====================================================
	// divider and countdown
	fic_tick #(.DIV(TICK_DIV)) u_tick (
		.mclk  (mclk),
		.rst_b (rst_b),
		.tick  (tick)
	);
	fic_count #(.W(32)) u_count (
		.mclk   (mclk),
		.rst_b  (rst_b),
		.tick   (tick),
		.arm_wr (arm_wr),
		.enable (ctl_r[`FIC_CTL_COUNTDOWN_ENABLE] && inj_on),
		.cyclic (ctl_r[`FIC_CTL_R]),
		.countdown_value    (cdn_r),
		.fire   (fire)
	);
	// =====================================================
	// pick one programmed type, uncontained first
	reg [31:0] inj_st;
	reg        inj_unc;
	reg        inj_def;
	always @* begin
		inj_st  = `FIC_ZERO32;
		inj_unc = 1'b0;
		inj_def = 1'b0;
		inj_st[`FIC_ST_V] = 1'b1;                                   // [RL15]
		if (types[`FIC_CTL_UC]) begin
			inj_st[`FIC_ST_UE] = 1'b1;
			inj_st[`FIC_ST_UET_LO+1:`FIC_ST_UET_LO] = `FIC_UET_UC;
			inj_unc = 1'b1;
		end else if (types[`FIC_CTL_UEU]) begin
			inj_st[`FIC_ST_UE] = 1'b1;
			inj_st[`FIC_ST_UET_LO+1:`FIC_ST_UET_LO] = `FIC_UET_UEU;
			inj_unc = 1'b1;
		end else if (types[`FIC_CTL_DE]) begin
			inj_st[`FIC_ST_DE] = 1'b1;
			inj_def = 1'b1;
		end else if (types[`FIC_CTL_CE]) begin
			inj_st[`FIC_ST_CE_LO+1:`FIC_ST_CE_LO] = `FIC_CE_ONE;
		end
	end
	wire do_inj = pend_r && node_access && inj_on && (types != 4'h0); // [RL14]
	// =====================================================
	// register writes, pending state and status record
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_r     <= `FIC_ZERO32;
			cdn_r     <= `FIC_ZERO32;
			rctl_r    <= 6'h00;
			status_r  <= `FIC_ZERO32;
			pend_r    <= 1'b0;                                       // [RL22]
			fault_p_r <= 1'b0;
			recov_p_r <= 1'b0;
		end else begin
			if (wr_ok && reg_addr == `FIC_A_CTL)
				ctl_r <= reg_wdata & `FIC_CTL_MASK;
			if (wr_ok && reg_addr == `FIC_A_CDN)
				cdn_r <= reg_wdata;
			if (wr_ok && reg_addr == `FIC_A_RCTL)
				rctl_r <= reg_wdata[5:0];
			// injection wins over a simultaneous clear
			if (do_inj)
				status_r <= inj_st;                          // [RL15] [RL16] [RL18]
			else if (wr_ok && reg_addr == `FIC_A_STATUS)
				status_r <= status_r & ~reg_wdata;
			if (!inj_on)
				pend_r <= 1'b0;                                      // [RL5]
			else if (fire)
				pend_r <= 1'b1;                                      // [RL13]
			else if (do_inj)
				pend_r <= 1'b0;                                      // [RL14]
			// edge pulses only for uncorrected and deferred types; no fault pulse for a corrected error even with CFI set
			fault_p_r <= do_inj && rctl_r[`FIC_RCTL_FI] && (inj_unc || inj_def); // [RL19]
			recov_p_r <= do_inj && ((inj_unc && rctl_r[`FIC_RCTL_UI])
			             || (inj_def && rctl_r[`FIC_RCTL_DUI]));    // [RL19]
		end
	end
	// =====================================================
	// level form reads only control and status [RL20]
	wire st_v   = status_r[`FIC_ST_V];
	wire lv_flt = st_v && ((rctl_r[`FIC_RCTL_FI] && (status_r[`FIC_ST_UE] || status_r[`FIC_ST_DE]))
	              || (rctl_r[`FIC_RCTL_CFI] && (status_r[`FIC_ST_CE_LO+1:`FIC_ST_CE_LO] != 2'h0)));
	wire lv_rec = st_v && ((rctl_r[`FIC_RCTL_UI] && status_r[`FIC_ST_UE])
	              || (rctl_r[`FIC_RCTL_DUI] && status_r[`FIC_ST_DE]));
	assign fault_irq = (LEVEL_IRQ != 0) ? lv_flt : fault_p_r;     // [RL2]
	assign recov_irq = (LEVEL_IRQ != 0) ? lv_rec : recov_p_r;     // [RL2]
	// =====================================================
	// node data path untouched; in-line response for both uncorrected types (UC and UEU)
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			node_data_out <= `FIC_ZERO32;
			inline_err    <= 1'b0;
			trap_top      <= 1'b0;
			trap_hyp      <= 1'b0;
		end else begin
			node_data_out <= node_data_in;                            // [RL1]
			inline_err    <= do_inj && inj_unc;                      // [RL2]
			trap_top      <= (reg_wr || reg_rd) && t_top;            // [RL7]
			trap_hyp      <= (reg_wr || reg_rd) && t_hyp;            // [RL8]
		end
	end
	// =====================================================
	// read data one cycle later; counter has no read path [RL11]
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= `FIC_ZERO32;
		end else if (rd_ok) begin
			case (reg_addr)
			`FIC_A_FEAT:   reg_rdata <= {28'h0000000, TYPES_OK};
			`FIC_A_CTL:    reg_rdata <= ctl_r;
			`FIC_A_CDN:    reg_rdata <= cdn_r;
			`FIC_A_RCTL:   reg_rdata <= {26'h0000000, rctl_r};
			`FIC_A_STATUS: reg_rdata <= status_r;
			`FIC_A_RFEAT:  reg_rdata <= {30'h00000000, rev_ok ? `FIC_INJ_YES : 2'h0}; // [RL3] [RL9]
			default:       reg_rdata <= `FIC_ZERO32;
			endcase
		end else begin
			reg_rdata <= `FIC_ZERO32;
		end
	end
	// single record node: injection registers live here [RL17]
endmodule // fic_top

// ---- verif/fic_top_assertions.sv ----
`timescale 1ns/1ps
module fic_chk (
	input wire        mclk,
	input wire        rst_b,
	input wire [3:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire        priv_low,
	input wire        priv_kernel,
	input wire        state_32,
	input wire        secure_inject_access_enable,
	input wire        hyp_inject_access_enable,
	input wire        el3_present,
	input wire        el2_active,
	input wire        node_access,
	input wire [31:0] node_data_in,
	input wire [31:0] node_data_out,
	input wire        inline_err,
	input wire        trap_top,
	input wire        trap_hyp,
	input wire        fault_irq,
	input wire        recov_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ==========
	// strobe to an injection register index
	wire stb = (reg_rd | reg_wr) & (reg_addr < 4'h3) & !state_32;
	wire top = el3_present & !secure_inject_access_enable;
	data_pass_a: assert property ($past(rst_b) |-> node_data_out == $past(node_data_in))
		else $error("node data altered");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
		else $error("read bus not quiet");
	narrow_block_a: assert property (reg_rd && state_32 && reg_addr < 4'h3 |=> reg_rdata == 0)
		else $error("narrow state read leaked");
	top_trap_a: assert property (stb && priv_low && top |=> trap_top)
		else $error("missing top trap");
	top_free_a: assert property ((reg_rd || reg_wr) && !el3_present |=> !trap_top)
		else $error("trap without top level");
	hyp_trap_a: assert property (stb && priv_kernel && el2_active && !top
		&& !hyp_inject_access_enable |=> trap_hyp)
		else $error("missing hyp trap");
	inline_cause_a: assert property (inline_err |-> $past(node_access) || $past(node_access, 2))
		else $error("inline error without access");
	fault_hold_a: assert property (!fault_irq && !reg_wr && !$past(reg_wr) && !node_access
		&& !$past(node_access) |=> !fault_irq)
		else $error("fault request without cause");
	recov_hold_a: assert property (recov_irq && !reg_wr && !$past(reg_wr) |=> recov_irq)
		else $error("recovery request dropped");
	cover property (inline_err);
	cover property (trap_top);
	cover property (fault_irq && !recov_irq);
endmodule // fic_chk
bind fic_top fic_chk i_fic_chk (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .priv_low(priv_low),
	.priv_kernel(priv_kernel), .state_32(state_32), .el3_present(el3_present),
	.secure_inject_access_enable(secure_inject_access_enable), .el2_active(el2_active),
	.hyp_inject_access_enable(hyp_inject_access_enable), .node_access(node_access),
	.node_data_in(node_data_in), .node_data_out(node_data_out), .inline_err(inline_err),
	.trap_top(trap_top), .trap_hyp(trap_hyp), .fault_irq(fault_irq), .recov_irq(recov_irq));

// ---- verif/fic_tb_top.sv ----
`timescale 1ns/1ps
module fic_tb_top;
	reg         mclk, rst_b, reg_wr, reg_rd, node_access, saw_inl;
	reg         priv_low, priv_kernel, state_32, sec_en, hyp_en, el3, el2, mm;
	reg  [3:0]  reg_addr, rev;
	reg  [31:0] reg_wdata, node_data_in, x, v;
	reg  [1:0]  tr;
	wire [31:0] reg_rdata, node_data_out;
	wire        inline_err, trap_top, trap_hyp, fault_irq, recov_irq;
	integer     error_cnt, checks_done, cyc, t, n;
	fic_top #(.TICK_DIV(2)) i_fic_top (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.priv_low(priv_low), .priv_kernel(priv_kernel), .state_32(state_32),
		.secure_inject_access_enable(sec_en), .hyp_inject_access_enable(hyp_en),
		.el3_present(el3), .el2_active(el2), .group_arch_revision(rev), .mm_group(mm),
		.node_access(node_access), .node_data_in(node_data_in), .node_data_out(node_data_out),
		.inline_err(inline_err), .trap_top(trap_top), .trap_hyp(trap_hyp),
		.fault_irq(fault_irq), .recov_irq(recov_irq));
	initial begin
		mclk = 0;
		forever #2.5 mclk = ~mclk;
	end
	// watchdog well above the few hundred cycles the run needs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (inline_err) saw_inl <= 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			tally_and_finish;
		end
	end
	// ==========
	// helpers
	function [31:0] nx(input [31:0] s);
		reg [31:0] y;
		begin
			y = s ^ (s << 13);
			y = y ^ (y >> 17);
			nx = y ^ (y << 5);
		end
	endfunction
	function [31:0] st_exp(input integer k);
		st_exp = 32'h40000000 | (k < 2 ? 32'h20000000 | (k << 20) :
			k == 2 ? 32'h02000000 : 32'h00800000);
	endfunction
	task chk(input [31:0] got, input [31:0] exp, input string m);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("unexpected at %0t: %0s got %h exp %h", $time, m, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
			@(posedge mclk) reg_wr <= 0;
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
			@(posedge mclk) reg_rd <= 0;
			@(negedge mclk) v = reg_rdata;
			tr = {trap_top, trap_hyp};
		end
	endtask
	task acc;
		begin
			x = nx(x);
			@(posedge mclk) {node_data_in, node_access} <= {x, 1'b1};
			@(posedge mclk) node_access <= 0;
			@(negedge mclk) chk(node_data_out, x, "node data");
		end
	endtask
	task tally_and_finish;
		begin
			if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
			else $display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// ==========
	// main sequence
	initial begin
		{mclk, rst_b, reg_wr, reg_rd, node_access, saw_inl, reg_addr, reg_wdata} = 0;
		{priv_low, priv_kernel, state_32, sec_en, hyp_en, el3, el2} = 0;
		{node_data_in, error_cnt, checks_done, cyc} = 0;
		{rev, mm, x} = {4'h1, 1'b1, 32'd41494};
		repeat (20) @(posedge mclk);
		rst_b <= 1;
		rd(0); chk(v[3:0], 4'hF, "types");
		rd(5); chk(v[1:0], 2'h1, "support");
		// each type once; early access must not inject
		for (t = 0; t < 4; t = t + 1) begin
			x = nx(x); n = 4 + x[2:0];
			wr(3, 32'h3D); wr(2, n); wr(1, 32'h80000000 | (1 << t));
			acc; rd(4); chk(v, 0, "early");
			repeat (2 * n + 8) @(posedge mclk);
			saw_inl = 0; acc; repeat (3) @(posedge mclk);
			rd(4); chk(v & 32'h63B00000, st_exp(t), "status");
			chk({fault_irq, recov_irq}, {1'b1, t != 2}, "irq");
			chk(saw_inl, t < 2, "inline");
			wr(4, 32'hFFFFFFFF); wr(1, 0);
			@(negedge mclk) chk({fault_irq, recov_irq}, 0, "irq clear");
		end
		// detection disabled, then cyclic reload twice
		wr(3, 32'h3C); wr(2, 4); wr(1, 32'h80000001); repeat (20) @(posedge mclk);
		acc; rd(4); chk(v, 0, "ed off");
		wr(3, 32'h3D); wr(2, 3); wr(1, 32'hC0000004);
		repeat (2) begin
			repeat (14) @(posedge mclk);
			acc; repeat (3) @(posedge mclk);
			rd(4); chk(v & 32'h63B00000, 32'h42000000, "cyclic");
			wr(4, 32'hFFFFFFFF);
		end
		wr(1, 0);
		rev <= 4'h0; repeat (4) @(posedge mclk);
		rd(5); chk(v[1:0], 0, "old revision");
		@(posedge mclk) rev <= 4'h1;
		@(posedge mclk) {priv_low, el3} <= 2'b11;
		rd(1); chk({v, tr}, 2'b10, "top trap");
		@(posedge mclk) {sec_en, priv_kernel, el2} <= 3'b111;
		rd(2); chk({v, tr}, 2'b01, "hyp trap");
		@(posedge mclk) {priv_low, priv_kernel, state_32} <= 3'b001;
		rd(2); chk(v, 0, "narrow");
		rd(5); chk(v[1:0], 2'h1, "narrow support");
		@(posedge mclk) state_32 <= 0;
		// reset while armed clears the counter before it can fire
		wr(3, 32'h3D); wr(2, 4); wr(1, 32'h80000001);
		rst_b <= 0; repeat (3) @(posedge mclk); rst_b <= 1;
		repeat (20) @(posedge mclk);
		wr(3, 32'h3D); // detection back on; reset also cleared the control types, so nothing is programmed to inject
		acc; rd(4); chk(v, 0, "after reset");
		tally_and_finish;
	end
endmodule // fic_tb_top
